// *** include/cht_pkg.sv ***
package cht_pkg;

  // ==========================================================================
  // Special function register addresses seen by the CPU.
  localparam logic [7:0] SFR_STATUS_RAMADDR = 8'hD8;
  localparam logic [7:0] SFR_IRQ_COMMAND    = 8'hD9;
  localparam logic [7:0] SFR_DATA_WINDOW    = 8'hDA;
  localparam logic [7:0] SFR_INDEX_POINTER  = 8'hDB;

  // ==========================================================================
  // Index pointer layout and reset value.
  localparam logic [7:0] INDEX_RESET     = 8'h64;
  localparam int         IDX_AUTOINC_BIT = 5;
  localparam int         IDX_DMA_BIT     = 7;
  localparam logic [4:0] IDX_SEL_TOP     = 5'h1F;

  // ==========================================================================
  // Internal controller register map.
  localparam int         INT_REGS      = 32;
  localparam logic [4:0] REG_BTR0      = 5'h06;
  localparam logic [4:0] REG_BTR1      = 5'h07;
  localparam logic [4:0] TXBUF_BASE    = 5'h0A;
  localparam logic [4:0] RXBUF_BASE    = 5'h14;
  localparam logic [4:0] RXBUF_LAST    = 5'h1D;
  localparam logic [4:0] DSCR2_OFS     = 5'h01;
  localparam logic [3:0] DESCR_BYTES   = 4'h2;
  localparam logic [3:0] MAX_DLC       = 4'h8;
  localparam logic [7:0] RAM_DLC_OFS   = 8'h01;
  localparam logic [2:0] IRQ_RSVD_BITS = 3'h7;

  // ==========================================================================
  // Bit timing field positions.
  localparam int BTR0_SJW_LSB   = 6;
  localparam int BTR1_SAM_BIT   = 7;
  localparam int BTR1_PHASE_SEG_AFTER_SAMPLE_LSB = 4;

  // ==========================================================================
  // Data path buffer.
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cht_cpu_req_t;

  typedef struct packed {
    logic [3:0] phase_seg_before_sample;
    logic [2:0] phase_seg_after_sample;
    logic [1:0] sync_jump_width;
    logic       triple_sample_select;
  } cht_btcfg_t;

  typedef enum logic [1:0] {
    BT_SYNC = 2'b00,
    BT_SEG1 = 2'b01,
    BT_SEG2 = 2'b10
  } cht_bt_state_t;

  typedef enum logic [2:0] {
    DMA_IDLE     = 3'b000,
    DMA_DLC_REQ  = 3'b001,
    DMA_DLC_WAIT = 3'b010,
    DMA_DLC_GET  = 3'b011,
    DMA_MOVE     = 3'b100
  } cht_dma_state_t;

endpackage

// *** src/cht_bit_timing.sv ***
`timescale 1ns/10ps
`default_nettype none

module cht_bit_timing (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire cht_pkg::cht_btcfg_t cfg_i,
  input  wire logic                bus_idle_i,
  input  wire logic                rx_i,
  output logic                     sample_o,
  output logic                     bit_o
);
  cht_pkg::cht_bt_state_t st_r;
  logic [4:0] cnt_r;
  logic [4:0] lim1_r;
  logic [4:0] lim2_r;
  logic       synced_r;
  logic       rx_d1_r;
  logic       rx_d2_r;
  logic [4:0] seg1;
  logic [4:0] seg2;
  logic [4:0] sync_jump_width;
  logic [4:0] mag;
  logic       edge_ok;
  logic       shorten;
  logic [4:0] lim2_eff;
  logic       maj;

  assign seg1     = 5'({1'b0, cfg_i.phase_seg_before_sample} + 5'h01);
  assign seg2     = 5'({2'b00, cfg_i.phase_seg_after_sample} + 5'h01);
  assign sync_jump_width      = 5'({3'b000, cfg_i.sync_jump_width} + 5'h01);
  assign mag      = 5'(lim2_r - cnt_r + 5'h01);
  assign edge_ok  = rx_d1_r && !rx_i && (rx_i != bit_o) && !synced_r;
  assign shorten  = edge_ok && (st_r == cht_pkg::BT_SEG2) && (mag > sync_jump_width);
  assign lim2_eff = shorten ? 5'(lim2_r - sync_jump_width) : lim2_r;
  assign maj      = (rx_i & rx_d1_r) | (rx_i & rx_d2_r) | (rx_d1_r & rx_d2_r);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_d1_r <= 1'b1;
      rx_d2_r <= 1'b1;
    end else begin
      rx_d1_r <= rx_i;
      rx_d2_r <= rx_d1_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r     <= cht_pkg::BT_SYNC;
      cnt_r    <= 5'h00;
      lim1_r   <= 5'h01;
      lim2_r   <= 5'h01;
      synced_r <= 1'b0;
      sample_o <= 1'b0;
      bit_o    <= 1'b1;
    end else begin
      sample_o <= 1'b0;
      if (edge_ok && bus_idle_i) begin
        st_r     <= cht_pkg::BT_SEG1;
        cnt_r    <= 5'h01;
        lim1_r   <= seg1;
        lim2_r   <= seg2;
        synced_r <= 1'b1;
      end else begin
        case (st_r)
          cht_pkg::BT_SYNC: begin
            st_r     <= cht_pkg::BT_SEG1;
            cnt_r    <= 5'h01;
            lim1_r   <= seg1;
            lim2_r   <= seg2;
            synced_r <= 1'b0;
          end
          cht_pkg::BT_SEG1: begin
            if (edge_ok) begin
              lim1_r   <= 5'(seg1 + ((cnt_r < sync_jump_width) ? cnt_r : sync_jump_width));
              synced_r <= 1'b1;
              cnt_r    <= 5'(cnt_r + 5'h01);
            end else if (cnt_r >= lim1_r) begin
              st_r     <= cht_pkg::BT_SEG2;
              cnt_r    <= 5'h01;
              sample_o <= 1'b1;
              bit_o    <= cfg_i.triple_sample_select ? maj : rx_i;
            end else begin
              cnt_r <= 5'(cnt_r + 5'h01);
            end
          end
          cht_pkg::BT_SEG2: begin
            if (edge_ok && !shorten) begin
              st_r     <= cht_pkg::BT_SEG1;
              cnt_r    <= 5'h01;
              lim1_r   <= seg1;
              synced_r <= 1'b1;
            end else begin
              if (shorten) begin
                lim2_r   <= lim2_eff;
                synced_r <= 1'b1;
              end
              if (cnt_r >= lim2_eff) begin
                st_r <= cht_pkg::BT_SYNC;
              end else begin
                cnt_r <= 5'(cnt_r + 5'h01);
              end
            end
          end
          default: begin
            st_r <= cht_pkg::BT_SYNC;
          end
        endcase
      end
    end
  end
endmodule // cht_bit_timing

`default_nettype wire

// *** src/cht_can_access.sv ***
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Index low five bits pick the internal register; bit 5 steps, bit 7 starts DMA.
// - Index resets to 64h, selecting the acceptance code register.
// - Data window reads and writes the internal register the index selects.
// - Port D9 reads interrupts, writes commands; D8 reads status, writes RAM address.
// - With step enable set, each data window access advances the index.
// - Stepping past the top select value clears step enable.
// - DMA moves up to ten bytes quickly, one byte per clock; receive RAM writes wait for ram_gnt_i.
// - DMA bit starts length evaluation; transmit length comes from RAM address plus one.
// - Index 8Ah copies descriptor and data bytes from RAM into transmit buffer.
// - Index 94h..9Dh copies receive buffer from that byte onward into RAM.
// - Finished DMA clears the DMA and step enable bits.
// - Interrupts are held off from DMA start until its end.
// - No DMA while the controller reset request is high.
// - A bit is sync slot, then first and second segments.
// - Sample at first segment end; segments 1..16 and 1..8, jump 1..4.
// - Bus sampled once or three times with majority, by configuration.
// - Hard sync on the first falling edge while the bus is idle.
// - Resync lengthens segment one or shortens segment two by jump width at most.
// - Phase error zero in sync slot, positive in segment one, negative in two.
// - Small errors act as hard sync; larger ones adjust by the jump width.
// - At most one sync per bit, only when level differs from last sample.
module cht_can_access (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire cht_pkg::cht_cpu_req_t cpu_req_i,
  output logic [7:0]                 cpu_rdata_o,
  input  wire logic [4:0]            ctl_irq_i,
  input  wire logic [7:0]            ctl_status_i,
  input  wire logic                  ctl_reset_req_i,
  output logic                       cmd_stb_o,
  output logic [7:0]                 cmd_data_o,
  input  wire logic                  rxbuf_we_i,
  input  wire logic [3:0]            rxbuf_idx_i,
  input  wire logic [7:0]            rxbuf_data_i,
  output logic [7:0]                 ram_addr_o,
  output logic                       ram_re_o,
  input  wire logic [7:0]            ram_rdata_i,
  output logic                       ram_we_o,
  output logic [7:0]                 ram_wdata_o,
  input  wire logic                  ram_gnt_i,
  output logic                       irq_hold_o,
  input  wire logic                  bus_idle_i,
  input  wire logic                  bus_rx_i,
  output logic                       sample_o,
  output logic                       rx_bit_o
);
  localparam int CW = $clog2(cht_pkg::FIFO_DEPTH + 1);

  // ==========================================================================
  // Shared helpers.
  function automatic logic [3:0] clip_dlc(input logic [3:0] dlc);
    clip_dlc = (dlc > cht_pkg::MAX_DLC) ? cht_pkg::MAX_DLC : dlc;
  endfunction

  function automatic logic [4:0] step_sel(input logic [4:0] sel);
    step_sel = 5'(sel + 5'h01);
  endfunction

  // ==========================================================================
  // State and wires.
  logic [7:0]              regs_r [cht_pkg::INT_REGS];
  logic [7:0]              index_r;
  logic [7:0]              ram_base_r;
  cht_pkg::cht_dma_state_t dma_st_r;
  logic                    dir_tx_r;
  logic [3:0]              total_r;
  logic [3:0]              src_r;
  logic [3:0]              dst_r;
  logic [4:0]              rx_first_r;
  logic                    rv_r;
  logic                    busy;
  logic                    wr_ok;
  logic                    rd_ok;
  logic                    win_acc;
  logic                    wr_index;
  logic                    tx_pick;
  logic                    rx_pick;
  logic                    start;
  logic [4:0]              rx_ofs;
  logic [3:0]              rx_end;
  logic                    done;
  logic                    issue_rd;
  logic                    f_in_valid;
  logic                    f_in_ready;
  logic [7:0]              f_in_data;
  logic                    f_out_valid;
  logic                    f_out_ready;
  logic [7:0]              f_out_data;
  logic [CW-1:0]           f_level;
  cht_pkg::cht_btcfg_t     bt_cfg;

  // ==========================================================================
  // CPU access decode.
  assign busy     = irq_hold_o;
  assign wr_ok    = cpu_req_i.wr && !busy;
  assign rd_ok    = cpu_req_i.rd && !busy;
  assign win_acc  = (wr_ok || rd_ok) && (cpu_req_i.addr == cht_pkg::SFR_DATA_WINDOW);
  assign wr_index = wr_ok && (cpu_req_i.addr == cht_pkg::SFR_INDEX_POINTER);
  assign tx_pick  = (cpu_req_i.wdata[4:0] == cht_pkg::TXBUF_BASE);
  assign rx_pick  = (cpu_req_i.wdata[4:0] >= cht_pkg::RXBUF_BASE) &&
                    (cpu_req_i.wdata[4:0] <= cht_pkg::RXBUF_LAST);
  // DMA bit starts, not in reset
  assign start    = wr_index && cpu_req_i.wdata[cht_pkg::IDX_DMA_BIT] && !ctl_reset_req_i &&
                    (tx_pick || rx_pick);
  assign rx_ofs   = 5'(cpu_req_i.wdata[4:0] - cht_pkg::RXBUF_BASE);
  assign rx_end   = 4'(cht_pkg::DESCR_BYTES +
                    clip_dlc(regs_r[5'(cht_pkg::RXBUF_BASE + cht_pkg::DSCR2_OFS)][3:0]));

  // ==========================================================================
  // Index pointer.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_r <= cht_pkg::INDEX_RESET;
    end else if (wr_index) begin
      index_r <= cpu_req_i.wdata;
    end else if (done) begin
      index_r[cht_pkg::IDX_DMA_BIT]     <= 1'b0;
      index_r[cht_pkg::IDX_AUTOINC_BIT] <= 1'b0;
    end else if (win_acc && index_r[cht_pkg::IDX_AUTOINC_BIT]) begin
      index_r[4:0] <= step_sel(index_r[4:0]);
      if (index_r[4:0] == cht_pkg::IDX_SEL_TOP) begin
        index_r[cht_pkg::IDX_AUTOINC_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // RAM address port and command port writes.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_base_r <= 8'h00;
      cmd_stb_o  <= 1'b0;
      cmd_data_o <= 8'h00;
    end else begin
      cmd_stb_o <= 1'b0;
      // write side of the mixed ports
      if (wr_ok && (cpu_req_i.addr == cht_pkg::SFR_STATUS_RAMADDR)) begin
        ram_base_r <= cpu_req_i.wdata;
      end
      if (wr_ok && (cpu_req_i.addr == cht_pkg::SFR_IRQ_COMMAND)) begin
        cmd_stb_o  <= 1'b1;
        cmd_data_o <= cpu_req_i.wdata;
      end
    end
  end

  // ==========================================================================
  // CPU read data.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_rdata_o <= 8'h00;
    end else if (rd_ok) begin
      case (cpu_req_i.addr)
        cht_pkg::SFR_INDEX_POINTER: cpu_rdata_o <= index_r;
        cht_pkg::SFR_DATA_WINDOW:   cpu_rdata_o <= regs_r[index_r[4:0]];
        // read side of the mixed ports
        cht_pkg::SFR_IRQ_COMMAND:   cpu_rdata_o <= {cht_pkg::IRQ_RSVD_BITS, ctl_irq_i};
        cht_pkg::SFR_STATUS_RAMADDR: cpu_rdata_o <= ctl_status_i;
        default:                    cpu_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Internal controller registers.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < cht_pkg::INT_REGS; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else begin
      if (win_acc && wr_ok) begin
        regs_r[index_r[4:0]] <= cpu_req_i.wdata;
      end
      if (f_out_valid && f_out_ready && dir_tx_r) begin
        regs_r[5'(cht_pkg::TXBUF_BASE + {1'b0, dst_r})] <= f_out_data;
      end
      if (rxbuf_we_i) begin
        regs_r[5'(cht_pkg::RXBUF_BASE + {1'b0, rxbuf_idx_i})] <= rxbuf_data_i;
      end
    end
  end

  // ==========================================================================
  // DMA sequencer.
  assign done = (dma_st_r == cht_pkg::DMA_MOVE) && (dst_r == total_r) && !f_out_valid &&
                !ram_re_o && !rv_r;
  assign issue_rd = (dma_st_r == cht_pkg::DMA_MOVE) && dir_tx_r && (src_r < total_r) &&
                    ((32'(f_level) + 32'(ram_re_o) + 32'(rv_r)) < 32'(cht_pkg::FIFO_DEPTH));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_st_r   <= cht_pkg::DMA_IDLE;
      dir_tx_r   <= 1'b0;
      total_r    <= 4'h0;
      rx_first_r <= 5'h00;
    end else begin
      case (dma_st_r)
        cht_pkg::DMA_IDLE: begin
          if (start) begin
            dir_tx_r   <= tx_pick;
            rx_first_r <= cpu_req_i.wdata[4:0];
            total_r    <= (rx_end > rx_ofs[3:0]) ? 4'(rx_end - rx_ofs[3:0]) : 4'h0;
            dma_st_r   <= tx_pick ? cht_pkg::DMA_DLC_REQ : cht_pkg::DMA_MOVE;
          end
        end
        cht_pkg::DMA_DLC_REQ:  dma_st_r <= cht_pkg::DMA_DLC_WAIT;
        cht_pkg::DMA_DLC_GET: begin
          total_r  <= 4'(cht_pkg::DESCR_BYTES + clip_dlc(ram_rdata_i[3:0]));
          dma_st_r <= cht_pkg::DMA_MOVE;
        end
        cht_pkg::DMA_DLC_WAIT: dma_st_r <= cht_pkg::DMA_DLC_GET;
        cht_pkg::DMA_MOVE: begin
          if (done) begin
            dma_st_r <= cht_pkg::DMA_IDLE;
          end
        end
        default: dma_st_r <= cht_pkg::DMA_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_hold_o <= 1'b0;
    end else if (start) begin
      irq_hold_o <= 1'b1;
    end else if (done) begin
      irq_hold_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Source and drain counters.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_r <= 4'h0;
      dst_r <= 4'h0;
    end else if (start) begin
      src_r <= 4'h0;
      dst_r <= 4'h0;
    end else begin
      if (issue_rd || (f_in_valid && f_in_ready && !dir_tx_r)) begin
        src_r <= 4'(src_r + 4'h1);
      end
      if (f_out_valid && f_out_ready) begin
        dst_r <= 4'(dst_r + 4'h1);
      end
    end
  end

  // ==========================================================================
  // Main RAM port.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_addr_o  <= 8'h00;
      ram_re_o    <= 1'b0;
      ram_we_o    <= 1'b0;
      ram_wdata_o <= 8'h00;
      rv_r        <= 1'b0;
    end else begin
      ram_re_o <= 1'b0;
      ram_we_o <= 1'b0;
      rv_r     <= ram_re_o && (dma_st_r == cht_pkg::DMA_MOVE);
      if (dma_st_r == cht_pkg::DMA_DLC_REQ) begin
        ram_re_o   <= 1'b1;
        ram_addr_o <= 8'(ram_base_r + cht_pkg::RAM_DLC_OFS);
      end else if (issue_rd) begin
        ram_re_o   <= 1'b1;
        ram_addr_o <= 8'(ram_base_r + {4'h0, src_r});
      end else if (f_out_valid && f_out_ready && !dir_tx_r) begin
        ram_we_o    <= 1'b1;
        ram_addr_o  <= 8'(ram_base_r + {4'h0, dst_r});
        ram_wdata_o <= f_out_data;
      end
    end
  end

  // ==========================================================================
  // Data path buffer.
  assign f_in_valid  = dir_tx_r ? rv_r :
                       ((dma_st_r == cht_pkg::DMA_MOVE) && (src_r < total_r));
  assign f_in_data   = dir_tx_r ? ram_rdata_i : regs_r[5'(rx_first_r + {1'b0, src_r})];
  assign f_out_ready = dir_tx_r || ram_gnt_i;

  cht_fifo #(
    .WIDTH (cht_pkg::FIFO_WIDTH),
    .DEPTH (cht_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data),
    .level_o     (f_level)
  );

  // ==========================================================================
  // Bit timing.
  // segment and jump fields
  assign bt_cfg.phase_seg_before_sample = regs_r[cht_pkg::REG_BTR1][3:0];
  assign bt_cfg.phase_seg_after_sample = regs_r[cht_pkg::REG_BTR1][cht_pkg::BTR1_PHASE_SEG_AFTER_SAMPLE_LSB +: 3];
  assign bt_cfg.sync_jump_width   = regs_r[cht_pkg::REG_BTR0][cht_pkg::BTR0_SJW_LSB +: 2];
  assign bt_cfg.triple_sample_select   = regs_r[cht_pkg::REG_BTR1][cht_pkg::BTR1_SAM_BIT];

  cht_bit_timing u_bit_timing (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .cfg_i      (bt_cfg),
    .bus_idle_i (bus_idle_i),
    .rx_i       (bus_rx_i),
    .sample_o   (sample_o),
    .bit_o      (rx_bit_o)
  );
endmodule // cht_can_access

`default_nettype wire

// *** src/cht_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

module cht_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]      level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [CW-1:0]    cnt_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_r != CW'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rptr_r];
  assign level_o     = cnt_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : AW'(wptr_r + 1'b1);
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : AW'(rptr_r + 1'b1);
      end
      if (push && !pop) begin
        cnt_r <= CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
        cnt_r <= CW'(cnt_r - 1'b1);
      end
    end
  end
endmodule // cht_fifo

`default_nettype wire

// *** tb/cht_can_access_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module cht_can_access_test;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, ctl_reset_req_i = 1'b0, rxbuf_we_i = 1'b0;
  logic ram_gnt_i = 1'b1, go = 1'b0;
  logic cmd_stb_o, ram_re_o, ram_we_o, irq_hold_o, sample_o, rx_bit_o, bus_rx_i, bus_idle_i;
  logic done;
  cht_pkg::cht_cpu_req_t cpu_req_i = '0;
  logic [7:0] ctl_status_i = 8'h00, ram_rdata_i = 8'h00, rxbuf_data_i = 8'h00;
  logic [7:0] cpu_rdata_o, cmd_data_o, ram_addr_o, ram_wdata_o, base, sel;
  logic [7:0] ram [256];
  logic [7:0] rxb [10];
  logic [4:0] ctl_irq_i = 5'h00;
  logic [3:0] rxbuf_idx_i = 4'h0, qpb = 4'h8;
  logic [15:0] frame = 16'hFFFF, cap = 16'hFFFF;
  int seed = 97, mismatches = 0, total_checks = 0;
  always #2.5 mclk_i = ~mclk_i;
  cht_can_access u_dut (.mclk_i, .rst_n_i, .cpu_req_i, .cpu_rdata_o, .ctl_irq_i,
    .ctl_status_i, .ctl_reset_req_i, .cmd_stb_o, .cmd_data_o, .rxbuf_we_i, .rxbuf_idx_i,
    .rxbuf_data_i, .ram_addr_o, .ram_re_o, .ram_rdata_i, .ram_we_o, .ram_wdata_o,
    .ram_gnt_i, .irq_hold_o, .bus_idle_i, .bus_rx_i, .sample_o, .rx_bit_o);
  cht_can_node u_node (.mclk_i, .go_i(go), .qpb_i(qpb), .frame_i(frame),
    .rx_o(bus_rx_i), .idle_o(bus_idle_i), .done_o(done));
  always @(posedge mclk_i) begin
    ram_rdata_i <= ram_re_o ? ram[ram_addr_o] : ~ram_rdata_i;
    ram_gnt_i <= ($random(seed) % 4) != 0;
    if (ram_we_o)
      ram[ram_addr_o] <= ram_wdata_o;
    if (sample_o)
      cap <= {cap[14:0], rx_bit_o};
  end
  function automatic int cnt(input logic [3:0] d, input int s);
    cnt = 2 + ((d > 4'h8) ? 8 : int'(d)) - s;
  endfunction
  task automatic acc(input logic r, w, input logic [7:0] a, d);
    @(posedge mclk_i);
    cpu_req_i <= {r, w, a, d};
    @(posedge mclk_i);
    cpu_req_i <= '0;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, exp);
    acc(1'b1, 1'b0, a, 8'h00);
    #1 chk(16'(cpu_rdata_o), 16'(exp));
  endtask
  task automatic wdma();
    #1;
    for (int k = 0; k < 60 && irq_hold_o; k++)
      @(posedge mclk_i);
    chk(16'(irq_hold_o), 16'h0);
  endtask
  task automatic close_out();
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    ctl_irq_i = 5'($random(seed));
    ctl_status_i = 8'($random(seed));
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rchk(8'hDB, 8'h64);
    rchk(8'hD9, {3'h7, ctl_irq_i});
    rchk(8'hD8, ctl_status_i);
    acc(1'b0, 1'b1, 8'hD9, 8'($random(seed)));
    for (int k = 0; k < 4; k++) begin
      sel = 8'($random(seed)) & 8'h7F;
      acc(1'b0, 1'b1, 8'hDB, sel);
      rchk(8'hDB, sel);
    end
    acc(1'b0, 1'b1, 8'hDB, 8'h0C);
    acc(1'b0, 1'b1, 8'hDA, sel);
    rchk(8'hDA, sel);
    acc(1'b0, 1'b1, 8'hDB, 8'h26);
    acc(1'b0, 1'b1, 8'hDA, 8'h40);
    acc(1'b0, 1'b1, 8'hDA, 8'h23);
    rchk(8'hDB, 8'h28);
    acc(1'b0, 1'b1, 8'hDB, 8'h3F);
    acc(1'b1, 1'b0, 8'hDA, 8'h00);
    rchk(8'hDB, 8'h00);
    base = 8'($random(seed));
    for (int k = 0; k < 10; k++)
      ram[8'(base + k)] = 8'($random(seed));
    acc(1'b0, 1'b1, 8'hD8, base);
    acc(1'b0, 1'b1, 8'hDB, 8'h8A);
    #1 chk(16'(irq_hold_o), 16'h1);
    wdma();
    rchk(8'hDB, 8'h0A);
    acc(1'b0, 1'b1, 8'hDB, 8'h2A);
    for (int k = 0; k < cnt(ram[8'(base + 1)][3:0], 0); k++)
      rchk(8'hDA, ram[8'(base + k)]);
    for (int k = 0; k < 10; k++) begin
      rxb[k] = 8'($random(seed));
      @(posedge mclk_i);
      rxbuf_we_i <= 1'b1;
      rxbuf_idx_i <= 4'(k);
      rxbuf_data_i <= rxb[k];
    end
    @(posedge mclk_i);
    rxbuf_we_i <= 1'b0;
    sel = 8'h94 + 8'({$random(seed)} % 10);
    acc(1'b0, 1'b1, 8'hD8, base);
    acc(1'b0, 1'b1, 8'hDB, sel);
    wdma();
    for (int k = 0; k < cnt(rxb[1][3:0], int'(sel[4:0]) - 20); k++)
      chk(16'(ram[8'(base + k)]), 16'(rxb[int'(sel[4:0]) - 20 + k]));
    @(posedge mclk_i);
    ctl_reset_req_i <= 1'b1;
    acc(1'b0, 1'b1, 8'hDB, 8'h8A);
    rchk(8'hDB, 8'h8A);
    @(posedge mclk_i);
    ctl_reset_req_i <= 1'b0;
    for (int q = 7; q < 10; q++) begin
      acc(1'b0, 1'b1, 8'hDB, 8'h07);
      acc(1'b0, 1'b1, 8'hDA, {q == 9, 7'h23});
      repeat (30) @(posedge mclk_i);
      go <= 1'b1;
      qpb <= 4'(q);
      frame <= (q == 8) ? 16'($random(seed)) & 16'h7FFF : 16'h5555;
      @(posedge mclk_i);
      go <= 1'b0;
      for (int k = 0; k < 400 && !done; k++)
        @(posedge mclk_i);
      chk(cap, frame);
    end
    close_out();
  end
endmodule // cht_can_access_test
bind cht_can_access cht_checker u_chk (.mclk_i, .rst_n_i, .cpu_req_i, .cpu_rdata_o,
  .ctl_irq_i, .ctl_reset_req_i, .cmd_stb_o, .cmd_data_o, .ram_addr_o, .ram_re_o,
  .ram_we_o, .irq_hold_o, .sample_o, .rx_bit_o);
`default_nettype wire

// *** tb/cht_can_node.sv ***
`timescale 1ns/10ps
`default_nettype none
module cht_can_node (
  input  wire logic        mclk_i,
  input  wire logic        go_i,
  input  wire logic [3:0]  qpb_i,
  input  wire logic [15:0] frame_i,
  output logic             rx_o,
  output logic             idle_o,
  output logic             done_o
);
  logic [15:0] sh_r = 16'hFFFF;
  logic [4:0]  nb_r = 5'h00;
  logic [3:0]  q_r = 4'h1;
  initial begin
    rx_o = 1'b1;
    idle_o = 1'b1;
    done_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    done_o <= 1'b0;
    q_r <= q_r - 4'h1;
    if (go_i) begin
      {rx_o, sh_r} <= {frame_i, 1'b1};
      nb_r <= 5'h0F;
      q_r <= qpb_i;
    end else if (!idle_o && q_r == 4'h1) begin
      {rx_o, sh_r} <= {sh_r, 1'b1};
      q_r <= qpb_i;
      nb_r <= nb_r - 5'h01;
      idle_o <= nb_r == 5'h00;
      done_o <= nb_r == 5'h00;
    end else if (nb_r == 5'h0F) begin
      idle_o <= 1'b0;
    end
  end
endmodule // cht_can_node
`default_nettype wire

// *** tb/cht_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module cht_checker (
  input wire logic                  mclk_i,
  input wire logic                  rst_n_i,
  input wire cht_pkg::cht_cpu_req_t cpu_req_i,
  input wire logic [7:0]            cpu_rdata_o,
  input wire logic [4:0]            ctl_irq_i,
  input wire logic                  ctl_reset_req_i,
  input wire logic                  cmd_stb_o,
  input wire logic [7:0]            cmd_data_o,
  input wire logic [7:0]            ram_addr_o,
  input wire logic                  ram_re_o,
  input wire logic                  ram_we_o,
  input wire logic                  irq_hold_o,
  input wire logic                  sample_o,
  input wire logic                  rx_bit_o
);
  logic       wr_w;
  logic [7:0] base_r;
  assign wr_w = cpu_req_i.wr && !irq_hold_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Tracks the RAM start address.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      base_r <= 8'h00;
    else if (wr_w && cpu_req_i.addr == 8'hD8)
      base_r <= cpu_req_i.wdata;
  end
  cmd_write_a: assert property (
    wr_w && cpu_req_i.addr == 8'hD9 |=> cmd_stb_o && cmd_data_o == $past(cpu_req_i.wdata))
    else $error("command write lost");
  irq_read_a: assert property (
    cpu_req_i.rd && !irq_hold_o && cpu_req_i.addr == 8'hD9
    |=> cpu_rdata_o == {3'h7, $past(ctl_irq_i)}) else $error("irq read wrong");
  tx_start_a: assert property (
    wr_w && !ctl_reset_req_i && cpu_req_i.addr == 8'hDB && cpu_req_i.wdata == 8'h8A
    |=> irq_hold_o ##1 (ram_re_o && ram_addr_o == base_r + 8'h01)) else $error("bad tx start");
  reset_block_a: assert property (
    wr_w && ctl_reset_req_i && cpu_req_i.addr == 8'hDB && cpu_req_i.wdata[7]
    |=> !irq_hold_o) else $error("dma under reset");
  dma_bound_a: assert property (
    $rose(irq_hold_o) |-> ##[1:30] !irq_hold_o) else $error("dma too long");
  ram_busy_a: assert property (
    ram_re_o || ram_we_o |-> irq_hold_o) else $error("ram access without hold");
  sample_pulse_a: assert property (
    sample_o |=> !sample_o) else $error("sample pulse too long");
  bit_update_a: assert property (
    !sample_o |-> $stable(rx_bit_o)) else $error("bit changed off sample");
endmodule // cht_checker
`default_nettype wire
